// ---- hdl/aios_pkg.sv ----
// register map and field layout for the analogue i/o status and calibration bank
package aios_pkg;
    localparam int unsigned ADDR_W = 6;
    // byte offsets, one aligned 32-bit word each
    localparam logic [5:0] OFF_DIAGNOSTIC_WORDS_FLAGS   = 6'h00;
    localparam logic [5:0] OFF_ACTIVE_SLOT  = 6'h04;
    localparam logic [5:0] OFF_IN_DISC      = 6'h08;
    localparam logic [5:0] OFF_OUT_DISC     = 6'h0c;
    localparam logic [5:0] OFF_LINE_FAULT   = 6'h10;
    localparam logic [5:0] OFF_CAL_SELECT   = 6'h14;
    localparam logic [5:0] OFF_CONFIG       = 6'h18;
    localparam logic [5:0] OFF_IRQ_STATUS   = 6'h1c;
    localparam logic [5:0] OFF_IRQ_ENABLE   = 6'h20;
    localparam logic [5:0] OFF_IRQ_CLEAR    = 6'h24;
    localparam logic [5:0] OFF_CAL_A        = 6'h28;
    localparam logic [5:0] OFF_CAL_B        = 6'h2c;
    localparam logic [5:0] OFF_CAL_C        = 6'h30;
    localparam logic [5:0] OFF_OUT_VALUE    = 6'h34;
    // diagnostic word field positions
    localparam int unsigned BIT_SLICE_A     = 0;
    localparam int unsigned BIT_SLICE_B     = 1;
    localparam int unsigned BIT_SLICE_C     = 2;
    localparam int unsigned BIT_OFFLINE     = 3;
    localparam int unsigned BIT_HOT_REPAIR  = 4;
    localparam int unsigned BIT_DISCREPANCY = 5;
    // config register fields
    localparam int unsigned BIT_CFG_MONITOR = 0;
    localparam int unsigned BIT_CFG_LINE    = 1;
    // interrupt status fields
    localparam int unsigned BIT_IRQ_SLICE   = 0;
    localparam int unsigned BIT_IRQ_OFFLINE = 1;
    localparam int unsigned BIT_IRQ_DISC    = 2;
    localparam int unsigned BIT_IRQ_LINE    = 3;
    localparam int unsigned BIT_IRQ_SCAN    = 4;
    localparam int unsigned IRQ_W           = 5;
    localparam int unsigned IN_CH           = 16;
    localparam int unsigned OUT_CH          = 4;
    localparam int unsigned VAL_W           = 16;
    localparam int unsigned SLOT_W          = 16;
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;
endpackage

// ---- hdl/aios_status_calibration_select.sv ----
// status, fault and calibration register bank for triplicated analogue i/o
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - diagnostic_words bits 0-2 flag slices A-C faulted
// - diagnostic_words bit 3 set while module offline
// - diagnostic_words bit 4 set during hot repair
// - diagnostic_words bit 5 set on any discrepancy
// - second diagnostic_words word holds active slot
// - input fault word: 16 channel discrepancy flags
// - output fault word one: 4 discrepancy flags
// - output fault word two: 4 line fault flags
// - calibration select chooses normal or calibration value
// - slice A converter uses calibration when selected
// - slice B converter uses calibration when selected
// - slice C converter uses calibration when selected
// - output discrepancy only checked with monitor configured
// - line faults need monitor and line testing
module aios_status_calibration_select (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // avalon-mm slave
    input  wire logic [5:0]               avsAddress,
    input  wire logic                     avsRead,
    input  wire logic                     avsWrite,
    input  wire logic [31:0]              avsWriteData,
    input  wire logic [3:0]               avsByteEnable,
    output logic [31:0]                   avsReadData,
    output logic                          avsWaitRequest,
    // module scan results, same clock domain
    input  wire logic                     scanDone,
    input  wire logic [2:0]               sliceFault,
    input  wire logic                     moduleOffline,
    input  wire logic                     hotRepairActive,
    input  wire logic [15:0]              activeSlot,
    input  wire logic [15:0]              inputChannelDisc,
    input  wire logic [3:0]               outputChannelMismatch,
    input  wire logic [3:0]               lineFaultDetect,
    // converter drive per slice, four channels packed low channel first
    output logic [63:0]                   sliceAValue,
    output logic [63:0]                   sliceBValue,
    output logic [63:0]                   sliceCValue,
    output logic                          irq
);
    logic [5:0]  diagReg;
    logic [15:0] slotReg;
    logic [15:0] inDiscReg;
    logic [3:0]  outDiscReg;
    logic [3:0]  lineReg;
    logic [3:0]  calSelReg;
    logic [1:0]  cfgReg;
    logic [63:0] calAReg;
    logic [63:0] calBReg;
    logic [63:0] calCReg;
    logic [63:0] outValReg;
    logic [4:0]  irqStatusReg;
    logic [4:0]  irqEnableReg;
    logic        ackReg;
    logic [31:0] readDataReg;
    logic        monitorOn;
    logic        lineTestOn;
    logic [3:0]  outDiscNext;
    logic [3:0]  lineNext;
    logic [4:0]  irqEvent;
    logic [4:0]  irqClear;
    logic        wrStrobe;
    logic [31:0] readMux;
    logic        anyDisc;
    logic        lane0;
    logic        wrCalSel;
    logic        wrConfig;
    logic        wrCalA;
    logic        wrCalB;
    logic        wrCalC;
    logic        wrOutVal;
    logic        wrIrqEnable;
    logic        wrIrqClear;

    assign monitorOn  = cfgReg[aios_pkg::BIT_CFG_MONITOR];
    assign lineTestOn = cfgReg[aios_pkg::BIT_CFG_LINE];
    assign outDiscNext = monitorOn ? outputChannelMismatch : 4'h0;
    assign lineNext = (monitorOn && lineTestOn) ? lineFaultDetect : 4'h0;
    assign anyDisc  = (|inputChannelDisc) | (|outDiscNext);

    // status capture on each completed scan, zero until the first one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            diagReg <= 6'h00;
        end else if (scanDone) begin
            diagReg[aios_pkg::BIT_SLICE_A]     <= sliceFault[0];
            diagReg[aios_pkg::BIT_SLICE_B]     <= sliceFault[1];
            diagReg[aios_pkg::BIT_SLICE_C]     <= sliceFault[2];
            diagReg[aios_pkg::BIT_OFFLINE]     <= moduleOffline;
            diagReg[aios_pkg::BIT_HOT_REPAIR]  <= hotRepairActive;
            diagReg[aios_pkg::BIT_DISCREPANCY] <= anyDisc;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slotReg <= 16'h0000;
        end else if (scanDone) begin
            slotReg <= activeSlot;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inDiscReg <= 16'h0000;
        end else if (scanDone) begin
            inDiscReg <= inputChannelDisc;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outDiscReg <= 4'h0;
        end else if (scanDone) begin
            outDiscReg <= outDiscNext;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lineReg <= 4'h0;
        end else if (scanDone) begin
            lineReg <= lineNext;
        end
    end

    // single wait state: answer on the second edge of a request
    assign avsWaitRequest = (avsRead | avsWrite) & ~ackReg;
    assign wrStrobe       = avsWrite & ackReg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ackReg <= 1'b0;
        end else begin
            ackReg <= (avsRead | avsWrite) & ~ackReg;
        end
    end

    // write decode; status offsets decode to nothing
    assign lane0       = avsByteEnable[0];
    assign wrCalSel    = wrStrobe && avsAddress == aios_pkg::OFF_CAL_SELECT && lane0;
    assign wrConfig    = wrStrobe && avsAddress == aios_pkg::OFF_CONFIG && lane0;
    assign wrCalA      = wrStrobe && avsAddress == aios_pkg::OFF_CAL_A;
    assign wrCalB      = wrStrobe && avsAddress == aios_pkg::OFF_CAL_B;
    assign wrCalC      = wrStrobe && avsAddress == aios_pkg::OFF_CAL_C;
    assign wrOutVal    = wrStrobe && avsAddress == aios_pkg::OFF_OUT_VALUE;
    assign wrIrqEnable = wrStrobe && avsAddress == aios_pkg::OFF_IRQ_ENABLE && lane0;
    assign wrIrqClear  = wrStrobe && avsAddress == aios_pkg::OFF_IRQ_CLEAR && lane0;

    // software control registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calSelReg <= 4'h0;
        end else if (wrCalSel) begin
            calSelReg <= avsWriteData[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgReg <= 2'h0;
        end else if (wrConfig) begin
            cfgReg <= avsWriteData[1:0];
        end
    end

    // value words: each write shifts in, the last one lands in channel one
    aios_value_shift #(
        .VAL_W (aios_pkg::VAL_W),
        .CH    (aios_pkg::OUT_CH)
    ) u_cal_a (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (wrCalA),
        .valueIn (avsWriteData[15:0]),
        .values  (calAReg)
    );

    aios_value_shift #(
        .VAL_W (aios_pkg::VAL_W),
        .CH    (aios_pkg::OUT_CH)
    ) u_cal_b (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (wrCalB),
        .valueIn (avsWriteData[15:0]),
        .values  (calBReg)
    );

    aios_value_shift #(
        .VAL_W (aios_pkg::VAL_W),
        .CH    (aios_pkg::OUT_CH)
    ) u_cal_c (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (wrCalC),
        .valueIn (avsWriteData[15:0]),
        .values  (calCReg)
    );

    aios_value_shift #(
        .VAL_W (aios_pkg::VAL_W),
        .CH    (aios_pkg::OUT_CH)
    ) u_out_val (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (wrOutVal),
        .valueIn (avsWriteData[15:0]),
        .values  (outValReg)
    );

    // interrupt events: fault present at a completed scan, or any completed scan
    assign irqEvent[aios_pkg::BIT_IRQ_SLICE]   = scanDone & (|sliceFault);
    assign irqEvent[aios_pkg::BIT_IRQ_OFFLINE] = scanDone & moduleOffline;
    assign irqEvent[aios_pkg::BIT_IRQ_DISC]    = scanDone & ((|inputChannelDisc) | (|outDiscNext));
    assign irqEvent[aios_pkg::BIT_IRQ_LINE]    = scanDone & (|lineNext);
    assign irqEvent[aios_pkg::BIT_IRQ_SCAN]    = scanDone;
    assign irqClear = wrIrqClear ? avsWriteData[4:0] : 5'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqStatusReg <= 5'h00;
        end else begin
            irqStatusReg <= (irqStatusReg & ~irqClear) | irqEvent;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqEnableReg <= 5'h00;
        end else if (wrIrqEnable) begin
            irqEnableReg <= avsWriteData[4:0];
        end
    end

    assign irq = |(irqStatusReg & irqEnableReg);

    always_comb begin
        case (avsAddress)
            aios_pkg::OFF_DIAGNOSTIC_WORDS_FLAGS:  readMux = {26'h0, diagReg};
            aios_pkg::OFF_ACTIVE_SLOT: readMux = {16'h0, slotReg};
            aios_pkg::OFF_IN_DISC:     readMux = {16'h0, inDiscReg};
            aios_pkg::OFF_OUT_DISC:    readMux = {28'h0, outDiscReg};
            aios_pkg::OFF_LINE_FAULT:  readMux = {28'h0, lineReg};
            aios_pkg::OFF_CAL_SELECT:  readMux = {28'h0, calSelReg};
            aios_pkg::OFF_CONFIG:      readMux = {30'h0, cfgReg};
            aios_pkg::OFF_IRQ_STATUS:  readMux = {27'h0, irqStatusReg};
            aios_pkg::OFF_IRQ_ENABLE:  readMux = {27'h0, irqEnableReg};
            default:                   readMux = aios_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readDataReg <= aios_pkg::RST_WORD;
        end else if (avsRead & ~ackReg) begin
            readDataReg <= readMux;
        end
    end
    assign avsReadData = readDataReg;

    // converter drive selection per channel, one selector per slice
    aios_slice_drive #(
        .VAL_W (aios_pkg::VAL_W),
        .CH    (aios_pkg::OUT_CH)
    ) u_drive_a (
        .clk      (clk),
        .rst_b    (rst_b),
        .calSel   (calSelReg),
        .normal   (outValReg),
        .calValue (calAReg),
        .drive    (sliceAValue)
    );

    aios_slice_drive #(
        .VAL_W (aios_pkg::VAL_W),
        .CH    (aios_pkg::OUT_CH)
    ) u_drive_b (
        .clk      (clk),
        .rst_b    (rst_b),
        .calSel   (calSelReg),
        .normal   (outValReg),
        .calValue (calBReg),
        .drive    (sliceBValue)
    );

    aios_slice_drive #(
        .VAL_W (aios_pkg::VAL_W),
        .CH    (aios_pkg::OUT_CH)
    ) u_drive_c (
        .clk      (clk),
        .rst_b    (rst_b),
        .calSel   (calSelReg),
        .normal   (outValReg),
        .calValue (calCReg),
        .drive    (sliceCValue)
    );
endmodule

// shift register of channel words, newest word in channel one
module aios_value_shift #(
    parameter int unsigned VAL_W = 16,
    parameter int unsigned CH    = 4
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                load,
    input  wire logic [VAL_W-1:0]    valueIn,
    output logic      [VAL_W*CH-1:0] values
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            values <= '0;
        end else if (load) begin
            values <= {values[VAL_W*(CH-1)-1:0], valueIn};
        end
    end
endmodule

// registered per-channel choice between normal and calibration value
module aios_slice_drive #(
    parameter int unsigned VAL_W = 16,
    parameter int unsigned CH    = 4
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [CH-1:0]       calSel,
    input  wire logic [VAL_W*CH-1:0] normal,
    input  wire logic [VAL_W*CH-1:0] calValue,
    output logic      [VAL_W*CH-1:0] drive
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            drive <= '0;
        end else begin
            for (int unsigned ch = 0; ch < CH; ch++) begin
                drive[ch*VAL_W +: VAL_W] <= calSel[ch] ? calValue[ch*VAL_W +: VAL_W]
                                                       : normal[ch*VAL_W +: VAL_W];
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/aios_status_calibration_select_assertions.sv ----
// concurrent checks on the status and calibration bank ports
`timescale 1ns/1ns
`default_nettype none
module aios_status_calibration_select_assertions (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [5:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [31:0] avsReadData,
    input wire logic        avsWaitRequest,
    input wire logic        scanDone,
    input wire logic [63:0] sliceAValue,
    input wire logic [63:0] sliceBValue,
    input wire logic [63:0] sliceCValue,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic acc;
    logic wacc;
    assign acc = avsRead && !avsWaitRequest;
    assign wacc = avsWrite && !avsWaitRequest;
    a_one_wait: assert property ((avsRead || avsWrite) && avsWaitRequest |=>
        !avsWaitRequest) else $error("wait state not single");
    a_diagnostic_words_upper: assert property (acc && avsAddress == 6'h00 |->
        avsReadData[31:6] == '0) else $error("diagnostic_words undefined bits set");
    a_slot_upper: assert property (acc && avsAddress == 6'h04 |->
        avsReadData[31:16] == '0) else $error("slot upper bits set");
    a_disc_upper: assert property (acc && avsAddress == 6'h0c |->
        avsReadData[31:4] == '0) else $error("output disc upper bits set");
    a_line_upper: assert property (acc && avsAddress == 6'h10 |->
        avsReadData[31:4] == '0) else $error("line fault upper bits set");
    a_reset_quiet: assert property ($rose(rst_b) |->
        sliceAValue == '0 && irq == 1'b0) else $error("outputs not zero after reset");
    a_cal_follow: assert property ($changed({sliceAValue, sliceBValue, sliceCValue}) |->
        $past(wacc, 2)) else $error("converter value changed without write");
    a_irq_rise: assert property ($rose(irq) |-> $past(scanDone) || $past(wacc))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wacc))
        else $error("irq fell without write");
    a_read_hold: assert property ($changed(avsReadData) |-> $past(avsRead))
        else $error("read data changed without read");
    c_scan: cover property (scanDone);
    c_irq: cover property ($rose(irq));
    c_cal: cover property ($changed(sliceAValue));
endmodule
bind aios_status_calibration_select aios_status_calibration_select_assertions u_chk (
    .clk            (clk),
    .rst_b          (rst_b),
    .avsAddress     (avsAddress),
    .avsRead        (avsRead),
    .avsWrite       (avsWrite),
    .avsReadData    (avsReadData),
    .avsWaitRequest (avsWaitRequest),
    .scanDone       (scanDone),
    .sliceAValue    (sliceAValue),
    .sliceBValue    (sliceBValue),
    .sliceCValue    (sliceCValue),
    .irq            (irq)
);
`default_nettype wire

// ---- sim/aios_slice_model.sv ----
// far-side model of the module slices delivering scan results
`timescale 1ns/1ns
`default_nettype none
module aios_slice_model (
    input  wire logic        clk,
    output logic             scanDone,
    output logic [44:0]      st
);
    logic [44:0] held = '0;
    initial scanDone = 1'b0;
    // levels are only guaranteed in the scan cycle
    assign st = scanDone ? held : ~held;
    task automatic scan(input logic [44:0] v);
        @(posedge clk);
        held <= v;
        scanDone <= 1'b1;
        @(posedge clk);
        scanDone <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- sim/aios_status_calibration_select_tb.sv ----
// self-checking bench for the analogue i/o status and calibration bank
`timescale 1ns/1ns
`default_nettype none
module aios_status_calibration_select_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [5:0]  avsAddress = '0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = '0;
    logic [3:0]  avsByteEnable = 4'hf;
    logic [31:0] avsReadData;
    logic        avsWaitRequest, scanDone, irq;
    logic [63:0] sliceAValue, sliceBValue, sliceCValue;
    logic [44:0] st;
    int          miscompares = 0, checks = 0, cyc = 0;
    aios_slice_model m (
        .clk      (clk),
        .scanDone (scanDone),
        .st       (st)
    );
    aios_status_calibration_select dut (
        .clk                   (clk),
        .rst_b                 (rst_b),
        .avsAddress            (avsAddress),
        .avsRead               (avsRead),
        .avsWrite              (avsWrite),
        .avsWriteData          (avsWriteData),
        .avsByteEnable         (avsByteEnable),
        .avsReadData           (avsReadData),
        .avsWaitRequest        (avsWaitRequest),
        .scanDone              (scanDone),
        .sliceFault            (st[2:0]),
        .moduleOffline         (st[3]),
        .hotRepairActive       (st[4]),
        .activeSlot            (st[20:5]),
        .inputChannelDisc      (st[36:21]),
        .outputChannelMismatch (st[40:37]),
        .lineFaultDetect       (st[44:41]),
        .sliceAValue           (sliceAValue),
        .sliceBValue           (sliceBValue),
        .sliceCValue           (sliceCValue),
        .irq                   (irq)
    );
    always #50 clk = ~clk;
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        // waitrequest and read data are taken at the same rising edge
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        q = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic wrr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        chk(q, e);
    endtask
    task automatic t_status;
        rdc(6'h00, 0);
        rdc(6'h08, 0);
        rdc(6'h3c, 0);
        m.scan({8'h0, 16'h8001, 16'h0007, 1'b0, 1'b1, 3'h5});
        rdc(6'h00, 32'h2d);
        rdc(6'h04, 32'h7);
        rdc(6'h08, 32'h8001);
        wrr(6'h00, 32'hffff);
        rdc(6'h00, 32'h2d);
        m.scan({8'h0, 16'h0, 16'h0003, 1'b1, 1'b0, 3'h2});
        rdc(6'h00, 32'h12);
        for (int c = 0; c < 4; c++) begin
            wrr(6'h18, c);
            m.scan({4'h5, 4'ha, 37'h0});
            rdc(6'h0c, c[0] ? 32'ha : 32'h0);
            rdc(6'h10, c == 3 ? 32'h5 : 32'h0);
        end
        $display("test status done");
    endtask
    task automatic t_cal;
        logic [3:0] sel;
        for (int s = 0; s < 4; s++)
            for (int n = 3; n >= 0; n--)
                wrr(s ? 6'(6'h24 + 4 * s) : 6'h34, 32'h100 * s + n);
        for (int k = 0; k < 2; k++) begin
            sel = k ? 4'ha : 4'h5;
            wrr(6'h14, sel);
            repeat (3) @(posedge clk);
            for (int n = 0; n < 4; n++) begin
                chk(sliceAValue[16*n+:16], sel[n] ? 16'h100 + n : n);
                chk(sliceBValue[16*n+:16], sel[n] ? 16'h200 + n : n);
                chk(sliceCValue[16*n+:16], sel[n] ? 16'h300 + n : n);
            end
        end
        $display("test cal done");
    endtask
    task automatic t_irq;
        wrr(6'h24, 32'h1f);
        wrr(6'h20, 32'h10);
        m.scan('0);
        @(negedge clk);
        chk(irq, 1);
        rdc(6'h1c, 32'h10);
        wrr(6'h20, 0);
        @(negedge clk);
        chk(irq, 0);
        wrr(6'h24, 32'h10);
        rdc(6'h1c, 0);
        wrr(6'h20, 32'h0f);
        m.scan({4'h1, 4'h2, 16'h0, 16'h0, 1'b0, 1'b1, 3'h1});
        @(negedge clk);
        chk(irq, 1);
        rdc(6'h1c, 32'h1f);
        wrr(6'h24, 32'h1f);
        rdc(6'h1c, 0);
        $display("test irq done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_status();
        t_cal();
        t_irq();
        give_verdict();
    end
endmodule
`default_nettype wire
